// >>> hw/chrs_parser.sv
`timescale 1ns/1ns
`default_nettype none
module chrs_parser #(
    parameter int NKEYS = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command byte stream from the serial target
    input wire chrs_pkg::chrs_byte_t cmd_in,
    output logic cmd_ready,
    // Key store usage marks
    input wire logic [NKEYS-1:0] key_sign_mark,
    // Crypto engine side
    output chrs_pkg::chrs_job_t job,
    output chrs_pkg::chrs_byte_t eng_data,
    output logic eng_req,
    output logic eng_abort,
    input wire logic eng_done,
    input wire logic sign_clear,
    input wire chrs_pkg::chrs_byte_t res_in,
    output logic res_ready,
    // Response towards the serial target
    output chrs_pkg::chrs_byte_t rsp,
    output logic status_valid,
    output logic [7:0] status_code,
    // Context state
    output logic hash_active,
    output logic sign_active
);
    if (NKEYS < 1 || NKEYS > int'(chrs_pkg::KEY_COUNT)) begin : g_chk
        $error("NKEYS out of range");
    end

    typedef enum logic [3:0] {
        S_FUNC, S_SUBOP, S_ALG, S_KEY, S_SRC, S_LEN, S_DATA, S_DST,
        S_COUNT, S_DRAIN, S_EXEC, S_RESP, S_STAT
    } chrs_state_t;

    chrs_state_t state, next_state, end_st;
    logic [7:0] code, next_code, hash_alg, rsp_left;
    logic [7:0] held;
    logic held_vld, take, ctx_any, need_dst, dst_ok, key_ok;
    logic [255:0] mark_ext;
    logic [7:0] b;

    assign take = cmd_in.valid && cmd_ready;
    assign b = cmd_in.data;
    assign ctx_any = hash_active || sign_active;
    assign need_dst = job.func == chrs_pkg::FN_RNG ||
        (job.func == chrs_pkg::FN_HASH &&
        (job.subop == chrs_pkg::SUB_FINAL ||
        job.subop == chrs_pkg::SUB_ONESHOT));
    assign dst_ok = b <= chrs_pkg::SRC_INT_MAX;
    assign mark_ext = 256'(key_sign_mark);
    assign key_ok = mark_ext[b];
    assign end_st = cmd_in.last ? S_STAT : S_DRAIN;

    always_comb begin
        next_state = state;
        next_code = code;
        unique case (state)
            S_FUNC: if (take) begin
                if (cmd_in.last) begin
                    next_code = chrs_pkg::ST_LENGTH;
                    next_state = S_STAT;
                end else if (b == chrs_pkg::FN_RNG) begin
                    if (ctx_any) begin
                        next_code = chrs_pkg::ST_ABORTED;
                        next_state = S_DRAIN;
                    end else begin
                        next_state = S_COUNT;
                    end
                end else if (b == chrs_pkg::FN_HASH ||
                        b == chrs_pkg::FN_SIGN) begin
                    next_state = S_SUBOP;
                end else begin
                    next_code = chrs_pkg::ST_PARAM;
                    next_state = S_DRAIN;
                end
            end
            S_SUBOP: if (take) begin
                next_state = end_st;
                if (ctx_any && (job.func != (hash_active ?
                        chrs_pkg::FN_HASH : chrs_pkg::FN_SIGN) ||
                        b == chrs_pkg::SUB_INIT ||
                        b == chrs_pkg::SUB_ONESHOT)) begin
                    next_code = chrs_pkg::ST_ABORTED;
                end else if (job.func == chrs_pkg::FN_SIGN) begin
                    if (b != chrs_pkg::SUB_INIT) begin
                        next_code = chrs_pkg::ST_PARAM;
                    end else if (cmd_in.last) begin
                        next_code = chrs_pkg::ST_LENGTH;
                    end else begin
                        next_state = S_ALG;
                    end
                end else if (b == chrs_pkg::SUB_INIT ||
                        b == chrs_pkg::SUB_ONESHOT) begin
                    if (cmd_in.last) begin
                        next_code = chrs_pkg::ST_LENGTH;
                    end else begin
                        next_state = S_ALG;
                    end
                end else if (b == chrs_pkg::SUB_UPDATE ||
                        b == chrs_pkg::SUB_FINAL) begin
                    if (!hash_active) begin
                        next_code = chrs_pkg::ST_REFUSED;
                    end else if (cmd_in.last) begin
                        next_code = chrs_pkg::ST_LENGTH;
                    end else begin
                        next_state = S_SRC;
                    end
                end else begin
                    next_code = chrs_pkg::ST_PARAM;
                end
            end
            S_ALG: if (take) begin
                next_state = end_st;
                if (job.func == chrs_pkg::FN_SIGN ?
                        b != chrs_pkg::ALG_ECDSA :
                        (b != chrs_pkg::ALG_SHA256 &&
                        b != chrs_pkg::ALG_SHA384)) begin
                    next_code = chrs_pkg::ST_PARAM;
                end else if (cmd_in.last) begin
                    next_code = chrs_pkg::ST_LENGTH;
                end else begin
                    next_state = job.func == chrs_pkg::FN_SIGN ?
                        S_KEY : S_SRC;
                end
            end
            S_KEY: if (take) begin
                next_state = end_st;
                if (b >= 8'(NKEYS)) begin
                    next_code = chrs_pkg::ST_PARAM;
                end else if (!key_ok) begin
                    next_code = chrs_pkg::ST_REFUSED;
                end else if (cmd_in.last) begin
                    next_code = chrs_pkg::ST_LENGTH;
                end else begin
                    next_state = S_SRC;
                end
            end
            S_SRC: if (take) begin
                next_state = end_st;
                if (!dst_ok) begin
                    next_code = chrs_pkg::ST_PARAM;
                end else if (cmd_in.last) begin
                    // Empty raw data is legal only with no trailing byte
                    if (b != chrs_pkg::SRC_CMDBUF || need_dst) begin
                        next_code = chrs_pkg::ST_LENGTH;
                    end else begin
                        next_state = S_EXEC;
                    end
                end else begin
                    next_state = b == chrs_pkg::SRC_CMDBUF ?
                        S_DATA : S_LEN;
                end
            end
            S_LEN: if (take) begin
                next_state = end_st;
                if (cmd_in.last == need_dst) begin
                    next_code = chrs_pkg::ST_LENGTH;
                end else begin
                    next_state = cmd_in.last ? S_EXEC : S_DST;
                end
            end
            S_DATA: if (take && cmd_in.last) begin
                if (need_dst && !dst_ok) begin
                    next_code = chrs_pkg::ST_PARAM;
                    next_state = S_STAT;
                end else begin
                    next_state = S_EXEC;
                end
            end
            S_COUNT: if (take) begin
                next_state = end_st;
                if (b == 8'h00 || b > chrs_pkg::RNG_MAX) begin
                    next_code = chrs_pkg::ST_REFUSED;
                end else if (cmd_in.last) begin
                    next_code = chrs_pkg::ST_LENGTH;
                end else begin
                    next_state = S_DST;
                end
            end
            S_DST: if (take) begin
                next_state = end_st;
                if (!dst_ok) begin
                    next_code = chrs_pkg::ST_PARAM;
                end else if (!cmd_in.last) begin
                    next_code = chrs_pkg::ST_LENGTH;
                end else begin
                    next_state = S_EXEC;
                end
            end
            S_DRAIN: if (take && cmd_in.last) begin
                next_state = S_STAT;
            end
            S_EXEC: if (eng_done) begin
                next_state = rsp_left != 8'h00 ? S_RESP : S_STAT;
            end
            S_RESP: if (res_in.valid && res_ready && rsp_left == 8'h01) begin
                next_state = S_STAT;
            end
            S_STAT: begin
                next_state = S_FUNC;
                next_code = chrs_pkg::ST_OK;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= S_FUNC;
            code <= chrs_pkg::ST_OK;
            cmd_ready <= 1'b0;
            res_ready <= 1'b0;
        end else begin
            state <= next_state;
            code <= next_code;
            // Stall the host while the engine works or results stream
            cmd_ready <= next_state != S_EXEC && next_state != S_RESP &&
                next_state != S_STAT;
            res_ready <= next_state == S_RESP;
        end
    end

    // Field capture
    always_ff @(posedge mclk) begin
        if (rst) begin
            job <= '0;
        end else if (take) begin
            unique case (state)
                S_FUNC: begin
                    job <= '0;
                    job.func <= b;
                end
                S_SUBOP: begin
                    job.subop <= b;
                    job.alg <= hash_alg;
                end
                S_ALG: job.alg <= b;
                S_KEY: job.key <= b;
                S_SRC: job.src <= b;
                S_LEN, S_COUNT: job.len <= b;
                S_DST: job.dst <= b;
                S_DATA: if (cmd_in.last && need_dst) begin
                    job.dst <= b;
                end
                default: ;
            endcase
        end
    end

    // Raw data: one-byte delay when a destination byte trails the data
    always_ff @(posedge mclk) begin
        if (rst) begin
            eng_data <= '0;
            held <= 8'h00;
            held_vld <= 1'b0;
        end else begin
            eng_data <= '0;
            if (state == S_FUNC) begin
                held_vld <= 1'b0;
            end
            if (state == S_DATA && take) begin
                if (!need_dst) begin
                    eng_data <= '{1'b1, b, cmd_in.last};
                end else if (cmd_in.last) begin
                    eng_data <= '{held_vld, held, held_vld};
                    held_vld <= 1'b0;
                end else begin
                    eng_data <= '{held_vld, held, 1'b0};
                    held <= b;
                    held_vld <= 1'b1;
                end
            end
        end
    end

    // Engine handshake and result streaming
    always_ff @(posedge mclk) begin
        if (rst) begin
            eng_req <= 1'b0;
            eng_abort <= 1'b0;
            rsp_left <= 8'h00;
            rsp <= '0;
            status_valid <= 1'b0;
            status_code <= chrs_pkg::ST_OK;
        end else begin
            eng_req <= next_state == S_EXEC && state != S_EXEC;
            eng_abort <= state < S_DRAIN &&
                (next_state == S_DRAIN || next_state == S_STAT);
            rsp <= '0;
            if (next_state == S_EXEC && state != S_EXEC) begin
                rsp_left <= 8'h00;
                // The destination byte is being taken on this very edge
                if (b == chrs_pkg::SRC_CMDBUF && need_dst) begin
                    if (job.func == chrs_pkg::FN_RNG) begin
                        rsp_left <= job.len;
                    end else begin
                        rsp_left <= job.alg == chrs_pkg::ALG_SHA384 ?
                            chrs_pkg::DIG384_BYTES :
                            chrs_pkg::DIG256_BYTES;
                    end
                end
            end else if (res_in.valid && res_ready) begin
                rsp <= '{1'b1, res_in.data, rsp_left == 8'h01};
                rsp_left <= rsp_left - 8'h01;
            end
            status_valid <= state == S_STAT;
            status_code <= state == S_STAT ? code : chrs_pkg::ST_OK;
        end
    end

    // Multipart context, held across commands
    always_ff @(posedge mclk) begin
        if (rst) begin
            hash_active <= 1'b0;
            hash_alg <= chrs_pkg::ALG_SHA256;
            sign_active <= 1'b0;
        end else begin
            if (state == S_EXEC && eng_done &&
                    job.func == chrs_pkg::FN_HASH) begin
                if (job.subop == chrs_pkg::SUB_INIT) begin
                    hash_active <= 1'b1;
                    hash_alg <= job.alg;
                end else if (job.subop == chrs_pkg::SUB_FINAL) begin
                    hash_active <= 1'b0;
                end
            end
            if (state == S_EXEC && eng_done &&
                    job.func == chrs_pkg::FN_SIGN) begin
                sign_active <= 1'b1;
            end else if (sign_clear) begin
                sign_active <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_rng_count_range: assert property (
        eng_req && job.func == chrs_pkg::FN_RNG |->
        job.len >= 8'h01 && job.len <= chrs_pkg::RNG_MAX)
        else $error("random count out of range");
    chk_rng_bad_count: assert property (
        state == S_COUNT && take && (b == 8'h00 || b > chrs_pkg::RNG_MAX)
        |=> code == chrs_pkg::ST_REFUSED)
        else $error("bad random count not refused");
    chk_update_no_ctx: assert property (
        state == S_SUBOP && take && !ctx_any &&
        job.func == chrs_pkg::FN_HASH && (b == chrs_pkg::SUB_UPDATE ||
        b == chrs_pkg::SUB_FINAL) |=> code == chrs_pkg::ST_REFUSED)
        else $error("orphan update not refused");
    chk_conflict_abort: assert property (
        state == S_FUNC && take && !cmd_in.last &&
        b == chrs_pkg::FN_RNG && ctx_any |=>
        state == S_DRAIN && code == chrs_pkg::ST_ABORTED)
        else $error("conflict not aborted");
    chk_digest_len: assert property (
        eng_req && job.func == chrs_pkg::FN_HASH && need_dst &&
        job.dst == chrs_pkg::SRC_CMDBUF |-> rsp_left ==
        (job.alg == chrs_pkg::ALG_SHA384 ? chrs_pkg::DIG384_BYTES :
        chrs_pkg::DIG256_BYTES))
        else $error("digest length wrong");
    chk_resp_status: assert property (
        rsp.valid && rsp.last |=> status_valid &&
        status_code == chrs_pkg::ST_OK)
        else $error("response not closed by status");
    chk_key_mark: assert property (
        state == S_KEY && take && b < 8'(NKEYS) && !key_ok |=>
        code == chrs_pkg::ST_REFUSED ##1 !sign_active)
        else $error("unmarked key accepted");
    chk_hash_ctx: assert property (
        state == S_EXEC && eng_done && job.func == chrs_pkg::FN_HASH &&
        job.subop == chrs_pkg::SUB_INIT |=>
        hash_active && hash_alg == $past(job.alg))
        else $error("hash context not kept");
    chk_sign_dst: assert property (
        eng_req && job.func == chrs_pkg::FN_SIGN |->
        job.dst == chrs_pkg::SRC_CMDBUF)
        else $error("signature not to command buffer");
    chk_update_alg: assert property (
        eng_req && job.func == chrs_pkg::FN_HASH &&
        job.subop == chrs_pkg::SUB_UPDATE |-> job.alg == hash_alg)
        else $error("update lost algorithm");

    cov_hash_oneshot: cover property (eng_req &&
        job.func == chrs_pkg::FN_HASH &&
        job.subop == chrs_pkg::SUB_ONESHOT);
    cov_rng_resp: cover property (rsp.valid && rsp.last &&
        job.func == chrs_pkg::FN_RNG);
    cov_sign_init: cover property (sign_active && !$past(sign_active));
    cov_abort: cover property (status_valid &&
        status_code == chrs_pkg::ST_ABORTED);
endmodule // chrs_parser
`default_nettype wire

// >>> inc/chrs_pkg.sv
`default_nettype none
package chrs_pkg;
    // Function selector, first command data byte
    localparam logic [7:0] FN_HASH = 8'h01;
    localparam logic [7:0] FN_RNG = 8'h02;
    localparam logic [7:0] FN_SIGN = 8'h03;
    // Sub-operation codes
    localparam logic [7:0] SUB_INIT = 8'h01;
    localparam logic [7:0] SUB_UPDATE = 8'h02;
    localparam logic [7:0] SUB_FINAL = 8'h03;
    localparam logic [7:0] SUB_ONESHOT = 8'h04;
    // Algorithms and key store size
    localparam logic [7:0] ALG_SHA256 = 8'h01;
    localparam logic [7:0] ALG_SHA384 = 8'h02;
    localparam logic [7:0] ALG_ECDSA = 8'h00;
    localparam logic [7:0] KEY_COUNT = 8'h05;
    // Source and destination codes
    localparam logic [7:0] SRC_CMDBUF = 8'h00;
    localparam logic [7:0] SRC_INT_MAX = 8'h0f;
    // Result sizes and limits
    localparam logic [7:0] DIG256_BYTES = 8'h20;
    localparam logic [7:0] DIG384_BYTES = 8'h30;
    localparam logic [7:0] RNG_MAX = 8'h80;
    localparam logic [7:0] SIG_BYTES = 8'h40;
    // Status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_REFUSED = 8'h9d;
    localparam logic [7:0] ST_ABORTED = 8'hca;
    localparam logic [7:0] ST_PARAM = 8'h9e;
    localparam logic [7:0] ST_LENGTH = 8'h7e;

    typedef struct packed {
        logic [7:0] func;
        logic [7:0] subop;
        logic [7:0] alg;
        logic [7:0] key;
        logic [7:0] src;
        logic [7:0] len;
        logic [7:0] dst;
    } chrs_job_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } chrs_byte_t;
endpackage
`default_nettype wire

// >>> tb/chrs_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module chrs_engine_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Job handshake
    input wire logic slow,
    input wire logic eng_req,
    output var logic eng_done,
    // Result bytes
    input wire logic res_ready,
    output var chrs_pkg::chrs_byte_t res_in
);
    logic busy;
    logic [3:0] wait_c;
    logic [7:0] left;
    logic [7:0] idx;
    logic [7:0] last_d;

    // Offers 128 bytes, as many as the largest job needs: the parser must cut the count for smaller jobs
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
            wait_c <= 4'h0;
            left <= 8'h00;
            idx <= 8'h00;
            last_d <= 8'h00;
            eng_done <= 1'b0;
        end else begin
            eng_done <= 1'b0;
            if (eng_req) begin
                busy <= 1'b1;
                wait_c <= slow ? 4'h6 : 4'h0;
                left <= 8'h00;
                idx <= 8'h00;
            end else if (busy) begin
                if (wait_c == 4'h0) begin
                    busy <= 1'b0;
                    eng_done <= 1'b1;
                    left <= 8'h80;
                end else begin
                    wait_c <= wait_c - 4'h1;
                end
            end else if (res_in.valid && res_ready) begin
                left <= left - 8'h01;
                idx <= idx + 8'h01;
                last_d <= res_in.data;
            end
        end
    end

    // Idle data line shows the inverse of the last byte, not a stale copy
    always_comb begin
        res_in.valid = (left != 8'h00);
        res_in.data = res_in.valid ? 8'ha0 + idx : ~last_d;
        res_in.last = (left == 8'h01);
    end
endmodule // chrs_engine_model
`default_nettype wire

// >>> tb/crypto_hash_rng_sign_cmd_parser_tb.sv
`timescale 1ns/1ns
`default_nettype none
module crypto_hash_rng_sign_cmd_parser_tb;
    logic mclk, rst, slow, sign_clear, cmd_ready, eng_req, eng_abort;
    logic eng_done, res_ready, status_valid, hash_active, sign_active;
    chrs_pkg::chrs_byte_t cmd_in, eng_data, res_in, rsp;
    chrs_pkg::chrs_job_t job;
    logic [4:0] key_sign_mark;
    logic [7:0] status_code;
    logic [7:0] c[$];
    int err_count, n_checks, cyc, nb, n_abort, n_data;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    chrs_parser #(.NKEYS(5)) u_dut (.mclk(mclk), .rst(rst),
        .cmd_in(cmd_in), .cmd_ready(cmd_ready),
        .key_sign_mark(key_sign_mark), .job(job), .eng_data(eng_data),
        .eng_req(eng_req), .eng_abort(eng_abort), .eng_done(eng_done),
        .sign_clear(sign_clear), .res_in(res_in), .res_ready(res_ready),
        .rsp(rsp), .status_valid(status_valid), .status_code(status_code),
        .hash_active(hash_active), .sign_active(sign_active));

    chrs_engine_model u_eng (.mclk(mclk), .rst(rst), .slow(slow),
        .eng_req(eng_req), .eng_done(eng_done), .res_ready(res_ready),
        .res_in(res_in));

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task cmp8(input string name, input logic [7:0] exp,
              input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task cmp1(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Each byte is held until an edge samples cmd_ready high
    task send;
        for (int i = 0; i < c.size(); i++) begin
            cmd_in = '{valid: 1'b1, data: c[i], last: i == c.size() - 1};
            do @(posedge mclk); while (cmd_ready !== 1'b1);
            #1;
        end
        cmd_in = '{valid: 1'b0, data: ~c[c.size() - 1], last: 1'b0};
    endtask

    // Engine bytes count up from a0, so order and count are both visible
    task run(input logic [7:0] st, input int n);
        nb = 0;
        n_abort = 0;
        n_data = 0;
        send;
        do begin
            @(posedge mclk);
            #1;
            if (rsp.valid === 1'b1) begin
                cmp8("rsp_data", 8'ha0 + nb[7:0], rsp.data);
                cmp1("rsp_last", nb == n - 1, rsp.last);
                nb++;
            end
        end while (status_valid !== 1'b1);
        cmp8("status", st, status_code);
        cmp8("rsp_count", n[7:0], nb[7:0]);
        // A command ending in any non-OK status discards its data exactly once
        cmp8("aborts", {7'h00, st != 8'h00}, n_abort[7:0]);
    endtask

    // Count engine-side pulses of the current command
    always @(posedge mclk) begin
        if (eng_abort === 1'b1)
            n_abort++;
        if (eng_data.valid === 1'b1)
            n_data++;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            summarize;
        end
    end

    initial begin
        cmd_in = '0;
        rst = 1'b1;
        slow = 1'b0;
        sign_clear = 1'b0;
        key_sign_mark = 5'b00100;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        cmp1("hash_active", 1'b0, hash_active);
        c = '{8'h02, 8'h02, 8'h00};
        run(8'h00, 2);
        slow = 1'b1;
        c = '{8'h02, 8'h80, 8'h00};
        run(8'h00, 128);
        c = '{8'h02, 8'h00, 8'h00};
        run(8'h9d, 0);
        c = '{8'h02, 8'h81, 8'h00};
        run(8'h9d, 0);
        slow = 1'b0;
        c = '{8'h01, 8'h04, 8'h01, 8'h00, 8'h11, 8'h22, 8'h33, 8'h00};
        run(8'h00, 32);
        cmp8("eng_bytes", 8'h03, n_data[7:0]);
        c = '{8'h01, 8'h04, 8'h02, 8'h01, 8'h05, 8'h00};
        run(8'h00, 48);
        c = '{8'h02, 8'h04, 8'h01};
        run(8'h00, 0);
        cmp8("job_dst", 8'h01, job.dst);
        cmp8("job_len", 8'h04, job.len);
        c = '{8'h01, 8'h04, 8'h01, 8'h00, 8'haa, 8'h03};
        run(8'h00, 0);
        c = '{8'h01, 8'h02, 8'h00, 8'h44};
        run(8'h9d, 0);
        c = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h55};
        run(8'h00, 0);
        cmp1("hash_active", 1'b1, hash_active);
        c = '{8'h02, 8'h04, 8'h00};
        run(8'hca, 0);
        c = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h04};
        run(8'hca, 0);
        c = '{8'h01, 8'h02, 8'h01, 8'h04};
        run(8'h00, 0);
        c = '{8'h01, 8'h03, 8'h00, 8'h66, 8'h77, 8'h00};
        run(8'h00, 48);
        cmp1("hash_active", 1'b0, hash_active);
        c = '{8'h03, 8'h01, 8'h00, 8'h01, 8'h00, 8'h12};
        run(8'h9d, 0);
        c = '{8'h03, 8'h01, 8'h00, 8'h05, 8'h00, 8'h12};
        run(8'h9e, 0);
        c = '{8'h03, 8'h01, 8'h00, 8'h02, 8'h03, 8'h10};
        run(8'h00, 0);
        cmp1("sign_active", 1'b1, sign_active);
        cmp8("job_key", 8'h02, job.key);
        cmp8("job_dst", 8'h00, job.dst);
        c = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h55};
        run(8'hca, 0);
        @(posedge mclk);
        #1 sign_clear = 1'b1;
        @(posedge mclk);
        #1 sign_clear = 1'b0;
        @(posedge mclk);
        #1 cmp1("sign_active", 1'b0, sign_active);
        c = '{8'h05, 8'h00};
        run(8'h9e, 0);
        summarize;
    end
endmodule // crypto_hash_rng_sign_cmd_parser_tb
`default_nettype wire
